//--- verilog/asf_pkg.sv
// package of constants for the alu status flag block
// Summary of operation
// - carry bit 7 set on carry/borrow
// - half carry bit 6 on nibble carry/borrow
// - add overflow: carry out of bit 6/7 mismatch
// - subtract overflow: borrow into one top bit
// - multiply overflow when product above FFh
// - divide always clears overflow
// - parity flag is accumulator odd parity
// - every reset clears all four flags
// - arithmetic updates three; multiply/divide clear carry
// - bit ops force or update carry only
// - status word lives at address D0h
// - special registers at 80h-FFh, direct only
// - special register with low nibble 0 or 8 is bit addressable
// - long jump loads 16-bit absolute target
// - two status bits select register bank
package asf_pkg;
    // ---------------------------------------------
    // addresses and fields
    // ---------------------------------------------
    localparam logic [7:0] ASF_PSW_ADDR = 8'hD0;
    localparam logic [7:0] ASF_SFR_BASE = 8'h80;
    localparam int ASF_BIT_CY = 7;
    localparam int ASF_BIT_AC = 6;
    localparam int ASF_BIT_F0 = 5;
    localparam int ASF_BIT_RS1 = 4;
    localparam int ASF_BIT_RS0 = 3;
    localparam int ASF_BIT_OV = 2;
    localparam int ASF_BIT_F1 = 1;
    localparam int ASF_BIT_P = 0;
    localparam logic [7:0] ASF_PSW_RESET = 8'h00;
    localparam logic [7:0] ASF_BYTE_MAX = 8'hFF;
    localparam logic [15:0] ASF_PC_RESET = 16'h0000;
    // ---------------------------------------------
    // operation codes
    // ---------------------------------------------
    typedef enum logic [4:0] {
        ASF_OP_NONE, ASF_OP_ADD, ASF_OP_SUM_CARRY_OP, ASF_OP_SUBTRACT_BORROW_OP, ASF_OP_MUL, ASF_OP_DIV,
        ASF_OP_DA, ASF_OP_RRC, ASF_OP_RLC, ASF_OP_SETC, ASF_OP_CLRC, ASF_OP_CPLC,
        ASF_OP_ANLC, ASF_OP_ANLNC, ASF_OP_ORLC, ASF_OP_ORLNC, ASF_OP_MOVC,
        ASF_OP_COMPARE_BRANCH_OP
    } asf_op_t;
endpackage

//--- verilog/asf_flag_if.sv
// interface carrying flag results between datapath and top
`timescale 1ns/1ps
interface asf_flag_if;
    logic cy_we;
    logic cy;
    logic ac_we;
    logic ac;
    logic ov_we;
    logic ov;
    modport producer (output cy_we, cy, ac_we, ac, ov_we, ov);
    modport consumer (input cy_we, cy, ac_we, ac, ov_we, ov);
endinterface

//--- verilog/asf_flag_calc.sv
// combinational flag generator for the arithmetic and bit operations
`timescale 1ns/1ps
module asf_flag_calc (
    // operation
    input wire asf_pkg::asf_op_t i_op,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic i_bit,
    input wire logic i_cy,
    // results
    asf_flag_if.producer flags
);
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] low7;
    logic c6;
    logic cin;
    logic [15:0] prod;
    logic [8:0] da_val;
    always_comb begin
        cin = (i_op == asf_pkg::ASF_OP_ADD) ? 1'b0 : i_cy;
        sum = 9'h000;
        nib = 5'h00;
        low7 = 8'h00;
        c6 = 1'b0;
        prod = 16'h0000;
        da_val = 9'h000;
        flags.cy_we = 1'b0;
        flags.cy = 1'b0;
        flags.ac_we = 1'b0;
        flags.ac = 1'b0;
        flags.ov_we = 1'b0;
        flags.ov = 1'b0;
        case (i_op)
            asf_pkg::ASF_OP_ADD, asf_pkg::ASF_OP_SUM_CARRY_OP: begin
                sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, cin};
                nib = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, cin};
                low7 = {1'b0, i_a[6:0]} + {1'b0, i_b[6:0]} + {7'h00, cin};
                c6 = low7[7];
                flags.cy_we = 1'b1;
                flags.cy = sum[8];
                flags.ac_we = 1'b1;
                flags.ac = nib[4];
                flags.ov_we = 1'b1;
                flags.ov = c6 ^ sum[8];
            end
            asf_pkg::ASF_OP_SUBTRACT_BORROW_OP: begin
                sum = {1'b0, i_a} - {1'b0, i_b} - {8'h00, cin};
                nib = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, cin};
                low7 = {1'b0, i_a[6:0]} - {1'b0, i_b[6:0]} - {7'h00, cin};
                c6 = low7[7];
                flags.cy_we = 1'b1;
                flags.cy = sum[8];
                flags.ac_we = 1'b1;
                flags.ac = nib[4];
                flags.ov_we = 1'b1;
                flags.ov = c6 ^ sum[8];
            end
            asf_pkg::ASF_OP_MUL: begin
                prod = i_a * i_b;
                flags.cy_we = 1'b1;
                flags.ov_we = 1'b1;
                flags.ov = (prod > {8'h00, asf_pkg::ASF_BYTE_MAX});
            end
            asf_pkg::ASF_OP_DIV: begin
                flags.cy_we = 1'b1;
                flags.ov_we = 1'b1;
                flags.ov = 1'b0;
            end
            asf_pkg::ASF_OP_DA: begin
                da_val = {1'b0, i_a};
                if (i_a[3:0] > 4'h9 || i_bit) begin
                    da_val = da_val + 9'h006;
                end
                if (da_val[7:4] > 4'h9 || da_val[8] || i_cy) begin
                    da_val = da_val + 9'h060;
                end
                flags.cy_we = 1'b1;
                flags.cy = da_val[8] | i_cy;
            end
            asf_pkg::ASF_OP_RRC: begin
                flags.cy_we = 1'b1;
                flags.cy = i_a[0];
            end
            asf_pkg::ASF_OP_RLC: begin
                flags.cy_we = 1'b1;
                flags.cy = i_a[7];
            end
            asf_pkg::ASF_OP_SETC: begin
                flags.cy_we = 1'b1;
                flags.cy = 1'b1;
            end
            asf_pkg::ASF_OP_CLRC: begin
                flags.cy_we = 1'b1;
            end
            asf_pkg::ASF_OP_CPLC: begin
                flags.cy_we = 1'b1;
                flags.cy = ~i_cy;
            end
            asf_pkg::ASF_OP_ANLC: begin
                flags.cy_we = 1'b1;
                flags.cy = i_cy & i_bit;
            end
            asf_pkg::ASF_OP_ANLNC: begin
                flags.cy_we = 1'b1;
                flags.cy = i_cy & ~i_bit;
            end
            asf_pkg::ASF_OP_ORLC: begin
                flags.cy_we = 1'b1;
                flags.cy = i_cy | i_bit;
            end
            asf_pkg::ASF_OP_ORLNC: begin
                flags.cy_we = 1'b1;
                flags.cy = i_cy | ~i_bit;
            end
            asf_pkg::ASF_OP_MOVC: begin
                flags.cy_we = 1'b1;
                flags.cy = i_bit;
            end
            asf_pkg::ASF_OP_COMPARE_BRANCH_OP: begin
                flags.cy_we = 1'b1;
                flags.cy = (i_a < i_b);
            end
            default: begin
                flags.cy_we = 1'b0;
            end
        endcase
    end
endmodule

//--- verilog/asf_status_top.sv
// status word register, special register decode and long jump target
`timescale 1ns/1ps
module asf_status_top (
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    // operation
    input wire asf_pkg::asf_op_t I_OP,
    input wire logic [7:0] I_OPND_A,
    input wire logic [7:0] I_OPND_B,
    input wire logic I_BIT_VAL,
    input wire logic [7:0] I_ACC,
    // direct byte access
    input wire logic I_DIR_WR,
    input wire logic [7:0] I_DIR_ADDR,
    input wire logic [7:0] I_DIR_WDATA,
    // bit access
    input wire logic I_BIT_WR,
    input wire logic [7:0] I_BIT_ADDR,
    input wire logic I_BIT_WDATA,
    // long jump
    input wire logic I_LONG_JUMP_OP,
    input wire logic [15:0] I_LONG_JUMP_OP_TARGET,
    // outputs
    output logic [7:0] O_PSW,
    output logic [7:0] O_DIR_RDATA,
    output logic O_SFR_SEL,
    output logic O_BIT_ADDRESSABLE,
    output logic O_PSW_SEL,
    output logic [1:0] O_BANK,
    output logic [4:0] O_BANK_BASE,
    output logic [15:0] O_PC
);
    // ---------------------------------------------
    // flag calculation
    // ---------------------------------------------
    asf_flag_if flags ();
    logic [7:0] psw_reg;
    logic [7:0] psw_next;
    logic [15:0] pc_reg;
    logic [15:0] pc_next;
    logic [7:0] bit_byte;
    logic [2:0] bit_pos;
    logic bit_hits_psw;
    asf_flag_calc u_calc (
        .i_op(I_OP),
        .i_a(I_OPND_A),
        .i_b(I_OPND_B),
        .i_bit(I_BIT_VAL),
        .i_cy(psw_reg[asf_pkg::ASF_BIT_CY]),
        .flags(flags)
    );
    // ---------------------------------------------
    // address decode
    // ---------------------------------------------
    always_comb begin
        O_SFR_SEL = I_DIR_ADDR[7];
        O_PSW_SEL = (I_DIR_ADDR == asf_pkg::ASF_PSW_ADDR);
        O_BIT_ADDRESSABLE = I_DIR_ADDR[7] && (I_DIR_ADDR[2:0] == 3'h0);
        bit_byte = {I_BIT_ADDR[7:3], 3'h0};
        bit_pos = I_BIT_ADDR[2:0];
        bit_hits_psw = I_BIT_WR && I_BIT_ADDR[7]
            && (bit_byte == asf_pkg::ASF_PSW_ADDR);
        O_DIR_RDATA = O_PSW_SEL ? psw_reg : 8'h00;
    end
    // ---------------------------------------------
    // next state
    // ---------------------------------------------
    always_comb begin
        psw_next = psw_reg;
        if (I_DIR_WR && O_PSW_SEL) begin
            psw_next = I_DIR_WDATA;
        end
        if (bit_hits_psw) begin
            psw_next[bit_pos] = I_BIT_WDATA;
        end
        if (flags.cy_we) begin
            psw_next[asf_pkg::ASF_BIT_CY] = flags.cy;
        end
        if (flags.ac_we) begin
            psw_next[asf_pkg::ASF_BIT_AC] = flags.ac;
        end
        if (flags.ov_we) begin
            psw_next[asf_pkg::ASF_BIT_OV] = flags.ov;
        end
        psw_next[asf_pkg::ASF_BIT_P] = ^I_ACC;
        pc_next = I_LONG_JUMP_OP ? I_LONG_JUMP_OP_TARGET : pc_reg;
    end
    // ---------------------------------------------
    // registers
    // ---------------------------------------------
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            psw_reg <= asf_pkg::ASF_PSW_RESET;
            pc_reg <= asf_pkg::ASF_PC_RESET;
        end else begin
            psw_reg <= psw_next;
            pc_reg <= pc_next;
        end
    end
    // ---------------------------------------------
    // outputs
    // ---------------------------------------------
    always_comb begin
        O_PSW = psw_reg;
        O_PC = pc_reg;
        O_BANK = {psw_reg[asf_pkg::ASF_BIT_RS1], psw_reg[asf_pkg::ASF_BIT_RS0]};
        O_BANK_BASE = {O_BANK, 3'h0};
    end
endmodule

//--- testbench/asf_status_top_properties.sv
// checker module and bind for the status word block
`timescale 1ns/1ps
module asf_status_top_props (
    // observed ports
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    input wire asf_pkg::asf_op_t I_OP,
    input wire logic [7:0] I_OPND_A,
    input wire logic [7:0] I_OPND_B,
    input wire logic [7:0] I_ACC,
    input wire logic I_LONG_JUMP_OP,
    input wire logic [15:0] I_LONG_JUMP_OP_TARGET,
    input wire logic [7:0] O_PSW,
    input wire logic [1:0] O_BANK,
    input wire logic [4:0] O_BANK_BASE,
    input wire logic [15:0] O_PC
);
    // ---------------------------------------------
    // properties
    // ---------------------------------------------
    logic [8:0] sum;
    assign sum = {1'b0, I_OPND_A} + {1'b0, I_OPND_B};
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RST_N);
    property p_rst; $rose(I_RST_N) |-> O_PSW == 8'h00 && O_PC == 16'h0000; endproperty
    a_rst: assert property (p_rst) else $error("flags not clear after reset");
    property p_par; $past(I_RST_N) |-> O_PSW[0] == ^$past(I_ACC); endproperty
    a_par: assert property (p_par) else $error("parity mismatch");
    property p_add; I_OP == asf_pkg::ASF_OP_ADD |=> O_PSW[7] == $past(sum[8]); endproperty
    a_add: assert property (p_add) else $error("add carry mismatch");
    property p_setc; I_OP == asf_pkg::ASF_OP_SETC |=> O_PSW[7]; endproperty
    a_setc: assert property (p_setc) else $error("carry not set");
    property p_mul; I_OP == asf_pkg::ASF_OP_MUL |=> !O_PSW[7] && $stable(O_PSW[6]) &&
        O_PSW[2] == ($past(I_OPND_A) * $past(I_OPND_B) > 16'h00FF); endproperty
    a_mul: assert property (p_mul) else $error("multiply flags mismatch");
    property p_div; I_OP == asf_pkg::ASF_OP_DIV |=> !O_PSW[2] && !O_PSW[7]; endproperty
    a_div: assert property (p_div) else $error("divide flags mismatch");
    property p_pc; I_LONG_JUMP_OP |=> O_PC == $past(I_LONG_JUMP_OP_TARGET); endproperty
    a_pc: assert property (p_pc) else $error("jump target mismatch");
    property p_bank; O_BANK == O_PSW[4:3] && O_BANK_BASE == {O_BANK, 3'b000}; endproperty
    a_bank: assert property (p_bank) else $error("bank select mismatch");
    c_add: cover property (I_OP == asf_pkg::ASF_OP_ADD);
    c_mul: cover property (I_OP == asf_pkg::ASF_OP_MUL);
    c_jmp: cover property (I_LONG_JUMP_OP);
endmodule
bind asf_status_top asf_status_top_props asf_status_top_props_i (.I_CORE_CLK, .I_RST_N, .I_OP,
    .I_OPND_A, .I_OPND_B, .I_ACC, .I_LONG_JUMP_OP, .I_LONG_JUMP_OP_TARGET, .O_PSW, .O_BANK, .O_BANK_BASE, .O_PC);

//--- testbench/alu_status_flags_tb.sv
// self-checking bench for the status flag block
`timescale 1ns/1ps
module alu_status_flags_tb;
    logic I_CORE_CLK, I_RST_N, I_BIT_VAL, I_DIR_WR, I_BIT_WR, I_BIT_WDATA, I_LONG_JUMP_OP;
    logic [7:0] I_OPND_A, I_OPND_B, I_ACC, I_DIR_ADDR, I_DIR_WDATA, I_BIT_ADDR;
    logic [15:0] I_LONG_JUMP_OP_TARGET, O_PC;
    logic [7:0] O_PSW, O_DIR_RDATA;
    logic O_SFR_SEL, O_BIT_ADDRESSABLE, O_PSW_SEL;
    logic [1:0] O_BANK;
    logic [4:0] O_BANK_BASE;
    asf_pkg::asf_op_t I_OP;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    asf_status_top asf_status_top_i (.I_CORE_CLK, .I_RST_N, .I_OP, .I_OPND_A, .I_OPND_B,
        .I_BIT_VAL, .I_ACC, .I_DIR_WR, .I_DIR_ADDR, .I_DIR_WDATA, .I_BIT_WR, .I_BIT_ADDR,
        .I_BIT_WDATA, .I_LONG_JUMP_OP, .I_LONG_JUMP_OP_TARGET, .O_PSW, .O_DIR_RDATA, .O_SFR_SEL,
        .O_BIT_ADDRESSABLE, .O_PSW_SEL, .O_BANK, .O_BANK_BASE, .O_PC);
    // ---------------------------------------------
    // clock, timeout and tasks
    // ---------------------------------------------
    initial begin
        I_CORE_CLK = 1'b0;
        forever #4 I_CORE_CLK = ~I_CORE_CLK;
    end
    always @(posedge I_CORE_CLK) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic t_op(input asf_pkg::asf_op_t o, input logic [7:0] x, input logic [7:0] y,
            input logic v);
        @(negedge I_CORE_CLK);
        I_OP = o;
        I_OPND_A = x;
        I_OPND_B = y;
        I_BIT_VAL = v;
        @(negedge I_CORE_CLK);
        I_OP = asf_pkg::ASF_OP_NONE;
    endtask
    task automatic cyop(input logic p, input asf_pkg::asf_op_t o, input logic [7:0] x,
            input logic [7:0] y, input logic v, input logic e);
        t_op(p ? asf_pkg::ASF_OP_SETC : asf_pkg::ASF_OP_CLRC, 8'h00, 8'h00, 1'b0);
        t_op(o, x, y, v);
        chk(O_PSW[7], e);
    endtask
    task automatic t_wr(input logic bw, input logic [7:0] ad, input logic [7:0] d);
        @(negedge I_CORE_CLK);
        I_DIR_ADDR = ad;
        I_BIT_ADDR = ad;
        I_DIR_WDATA = d;
        I_BIT_WDATA = d[0];
        I_DIR_WR = !bw;
        I_BIT_WR = bw;
        @(negedge I_CORE_CLK);
        I_DIR_WR = 1'b0;
        I_BIT_WR = 1'b0;
    endtask
    task automatic t_rd(input logic [7:0] ad, input logic [7:0] d, input logic [2:0] s);
        @(negedge I_CORE_CLK);
        I_DIR_ADDR = ad;
        I_BIT_ADDR = ad;
        #1;
        chk({O_DIR_RDATA, O_SFR_SEL, O_PSW_SEL, O_BIT_ADDRESSABLE}, {d, s});
    endtask
    task automatic t_lj(input logic [15:0] t);
        @(negedge I_CORE_CLK);
        I_LONG_JUMP_OP = 1'b1;
        I_LONG_JUMP_OP_TARGET = t;
        @(negedge I_CORE_CLK);
        I_LONG_JUMP_OP = 1'b0;
        chk(O_PC, t);
    endtask
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        {I_RST_N, I_BIT_VAL, I_DIR_WR, I_BIT_WR, I_BIT_WDATA, I_LONG_JUMP_OP} = 6'h00;
        {I_OPND_A, I_OPND_B, I_DIR_ADDR, I_DIR_WDATA, I_BIT_ADDR, I_LONG_JUMP_OP_TARGET} = 56'h0;
        I_ACC = 8'h07;
        I_OP = asf_pkg::ASF_OP_NONE;
        repeat (2) @(negedge I_CORE_CLK);
        I_RST_N = 1'b1;
        chk({O_PSW, O_PC}, 24'h0);
        t_op(asf_pkg::ASF_OP_ADD, 8'h7F, 8'h01, 1'b0); chk(O_PSW, 8'h45);
        t_op(asf_pkg::ASF_OP_ADD, 8'hFF, 8'h01, 1'b0); chk(O_PSW, 8'hC1);
        t_op(asf_pkg::ASF_OP_SUM_CARRY_OP, 8'h01, 8'h01, 1'b0); chk(O_PSW, 8'h01);
        t_op(asf_pkg::ASF_OP_SUBTRACT_BORROW_OP, 8'h80, 8'h01, 1'b0); chk(O_PSW, 8'h45);
        t_op(asf_pkg::ASF_OP_SETC, 8'h00, 8'h00, 1'b0); chk(O_PSW, 8'hC5);
        t_op(asf_pkg::ASF_OP_MUL, 8'h10, 8'h10, 1'b0); chk(O_PSW, 8'h45);
        t_op(asf_pkg::ASF_OP_MUL, 8'h0F, 8'h11, 1'b0); chk(O_PSW, 8'h41);
        t_op(asf_pkg::ASF_OP_MUL, 8'h10, 8'h10, 1'b0); chk(O_PSW, 8'h45);
        t_op(asf_pkg::ASF_OP_DIV, 8'h10, 8'h02, 1'b0); chk(O_PSW, 8'h41);
        cyop(1'b1, asf_pkg::ASF_OP_CLRC, 8'h00, 8'h00, 1'b0, 1'b0);
        cyop(1'b0, asf_pkg::ASF_OP_CPLC, 8'h00, 8'h00, 1'b0, 1'b1);
        cyop(1'b1, asf_pkg::ASF_OP_ANLC, 8'h00, 8'h00, 1'b0, 1'b0);
        cyop(1'b1, asf_pkg::ASF_OP_ANLNC, 8'h00, 8'h00, 1'b0, 1'b1);
        cyop(1'b0, asf_pkg::ASF_OP_ORLC, 8'h00, 8'h00, 1'b1, 1'b1);
        cyop(1'b0, asf_pkg::ASF_OP_ORLNC, 8'h00, 8'h00, 1'b1, 1'b0);
        cyop(1'b1, asf_pkg::ASF_OP_MOVC, 8'h00, 8'h00, 1'b0, 1'b0);
        cyop(1'b0, asf_pkg::ASF_OP_DA, 8'h9A, 8'h00, 1'b0, 1'b1);
        cyop(1'b0, asf_pkg::ASF_OP_RRC, 8'h01, 8'h00, 1'b0, 1'b1);
        cyop(1'b1, asf_pkg::ASF_OP_RLC, 8'h01, 8'h00, 1'b0, 1'b0);
        cyop(1'b0, asf_pkg::ASF_OP_COMPARE_BRANCH_OP, 8'h01, 8'h02, 1'b0, 1'b1);
        I_ACC = 8'h00;
        t_wr(1'b0, 8'hD0, 8'hFF); chk(O_PSW, 8'hFE);
        chk({O_BANK, O_BANK_BASE}, {2'h3, 5'h18});
        t_wr(1'b0, 8'hC0, 8'h00); chk(O_PSW, 8'hFE);
        t_wr(1'b1, 8'hD7, 8'h00); chk(O_PSW, 8'h7E);
        t_wr(1'b1, 8'hD0, 8'h01); chk(O_PSW, 8'h7E);
        t_rd(8'hD0, 8'h7E, 3'b111);
        t_rd(8'h88, 8'h00, 3'b101);
        t_rd(8'h89, 8'h00, 3'b100);
        t_rd(8'h78, 8'h00, 3'b000);
        t_lj(16'hF732);
        t_lj(16'hFFFF);
        @(negedge I_CORE_CLK);
        I_RST_N = 1'b0;
        #1;
        chk({O_PSW, O_PC}, 24'h0);
        @(negedge I_CORE_CLK);
        I_RST_N = 1'b1;
        t_op(asf_pkg::ASF_OP_ADD, 8'hFF, 8'h01, 1'b0); chk(O_PSW, 8'hC0);
        final_report();
    end
endmodule
